// *** rtl/agclf_gain_if.sv ***
// Gain set handed from the loop filter to the error scaler
`timescale 1ns/10ps
interface agclf_gain_if;
	import agclf_pkg::*;
	agclf_nib_t man;
	agclf_nib_t expo;
	agclf_err_t err;
	logic signed [31:0] step;
	modport src (output man, output expo, output err, input step);
	modport dst (input man, input expo, input err, output step);
endinterface

// *** rtl/agclf_loop.sv ***
// AGC loop filter: error detector, two gain sets, clamped accumulator
`timescale 1ns/10ps
module agclf_loop
	import agclf_pkg::*;
(
	input wire logic CLK_SYS_I, // 250 MHz clock
	input wire logic RST_I, // Synchronous reset, active high
	input wire logic SAMPLE_I, // One-cycle pulse per output sample
	input wire logic [12:0] MAGNITUDE_I, // Converter magnitude, unsigned
	input wire logic [31:0] AGC_GAIN_LIMITS_I, // Limit control word
	input wire logic [31:0] LOOP_PARAM_I, // Threshold and gain sets
	input wire logic [31:0] MODE_WORD_I, // Hold and median mode bits
	input wire logic LOOP_GAIN_SET_SELECT_I, // Gain set select pin
	input wire logic SYNC_INPUT_TWO_I, // Sync-input reset pulse
	input wire logic BACKEND_SOFT_RESET_WORD_I, // Backend soft reset
	output logic [3:0] GAIN_EXP_O, // Multiplier/shifter exponent
	output logic [7:0] GAIN_MAN_O, // Multiplier/shifter mantissa
	output logic GAIN_VALID_O // Pulse when gain control updates
);
	`include "agclf_params.svh"

	// Error and gain set reach the scaler through the carrier
	agclf_gain_if g ();

	agclf_scaler u_scaler (
		.g(g) // Scaled step returns on the same carrier
	);

	// Limit fields and their accumulator-aligned forms
	agclf_nib_t up_exp;
	logic [7:0] up_man;
	agclf_nib_t lo_exp;
	logic [7:0] lo_man;
	agclf_acc_t up_lim;
	agclf_acc_t lo_lim;

	// Error detector
	agclf_err_t thr;
	agclf_err_t true_err;
	agclf_err_t med_err;
	logic err_neg;

	// Two loop gain sets
	agclf_nib_t g0_man;
	agclf_nib_t g0_exp;
	agclf_nib_t g1_man;
	agclf_nib_t g1_exp;

	// Mode and clear decode
	logic median_mode;
	logic hold_on_soft;
	logic sync_clear;
	logic soft_clear;
	logic clear;

	// Two guard bits hold the largest step on a full accumulator
	logic signed [33:0] sum;
	logic signed [33:0] up_wide;
	logic signed [33:0] lo_wide;
	logic over_up;
	logic under_lo;
	agclf_acc_t clamped;

	// Registered state; the gain word is what the multiplier/shifter sees
	agclf_acc_t acc;
	agclf_acc_t next_acc;
	logic [11:0] gain_ctl;
	logic [11:0] next_gain_ctl;
	logic gain_valid;
	logic next_gain_valid;

	// Limit word: exponent above mantissa, upper limit in the top half
	always_comb begin
		up_exp = AGC_GAIN_LIMITS_I[`AGCLF_UP_EXP_MSB:
			`AGCLF_UP_EXP_LSB];
		up_man = AGC_GAIN_LIMITS_I[`AGCLF_UP_MAN_MSB:
			`AGCLF_UP_MAN_LSB];
		lo_exp = AGC_GAIN_LIMITS_I[`AGCLF_LO_EXP_MSB:
			`AGCLF_LO_EXP_LSB];
		lo_man = AGC_GAIN_LIMITS_I[`AGCLF_LO_MAN_MSB:
			`AGCLF_LO_MAN_LSB];
		// Bit 31 of the accumulator never carries gain
		up_lim = {1'h0, up_exp, up_man,
			19'h00000};
		lo_lim = {1'h0, lo_exp, lo_man,
			19'h00000};
	end

	// The threshold MSB is zero, so the 13-bit difference keeps its
	// sign for any magnitude below 4096
	always_comb begin
		thr = LOOP_PARAM_I[`AGCLF_THR_MSB:`AGCLF_THR_LSB];
		true_err = thr - MAGNITUDE_I;
		// Sign from the wide compare, not from the wrapped difference
		err_neg = (MAGNITUDE_I > thr);
		if (err_neg) begin
			med_err = `AGCLF_MED_NEG;
		end else begin
			med_err = `AGCLF_MED_POS;
		end
	end

	// Mode bits are levels and act on the sample of the same cycle
	always_comb begin
		median_mode = MODE_WORD_I[`AGCLF_MEDIAN_BIT];
		hold_on_soft = MODE_WORD_I[`AGCLF_HOLD_BIT];
		sync_clear = SYNC_INPUT_TWO_I;
		// A held soft reset still lets the sync input clear
		soft_clear = BACKEND_SOFT_RESET_WORD_I && !hold_on_soft;
		clear = sync_clear || soft_clear;
	end

	// Set 0 in the low byte, set 1 above it; mantissa below exponent
	always_comb begin
		g0_man = LOOP_PARAM_I[`AGCLF_G0_MAN_MSB:`AGCLF_G0_MAN_LSB];
		g0_exp = LOOP_PARAM_I[`AGCLF_G0_EXP_MSB:`AGCLF_G0_EXP_LSB];
		g1_man = LOOP_PARAM_I[`AGCLF_G1_MAN_MSB:`AGCLF_G1_MAN_LSB];
		g1_exp = LOOP_PARAM_I[`AGCLF_G1_EXP_MSB:`AGCLF_G1_EXP_LSB];
	end

	// Median errors pass the same scaler, so their step size still
	// follows the selected loop gain
	always_comb begin
		if (median_mode) begin
			g.err = med_err;
		end else begin
			g.err = true_err;
		end
		// The scaler weights by mantissa over 16, then shifts
		if (LOOP_GAIN_SET_SELECT_I) begin
			g.man = g1_man;
			g.expo = g1_exp;
		end else begin
			g.man = g0_man;
			g.expo = g0_exp;
		end
	end

	// Clamp in the wide domain so no wrap escapes the limits; a lower
	// limit programmed above the upper one wins only for sums not above the upper limit
	always_comb begin
		sum = $signed({2'h0, acc}) + 34'(g.step);
		up_wide = $signed({2'h0, up_lim});
		lo_wide = $signed({2'h0, lo_lim});
		over_up = (sum > up_wide);
		under_lo = (sum < lo_wide);
		if (over_up) begin
			clamped = up_lim;
		end else if (under_lo) begin
			clamped = lo_lim;
		end else begin
			clamped = sum[31:0];
		end
	end

	// Accumulator: a clear wins over a sample in the same cycle;
	// samples may come back to back, each moving it once
	always_comb begin
		next_acc = acc;
		if (clear) begin
			next_acc = `AGCLF_WORD_RST;
		end else if (SAMPLE_I) begin
			next_acc = clamped;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			acc <= `AGCLF_WORD_RST;
		end else begin
			acc <= next_acc;
		end
	end

	// Gain control: a clear leaves the last gain on the outputs until
	// the next sample lands
	always_comb begin
		next_gain_ctl = gain_ctl;
		next_gain_valid = 1'h0;
		if (!clear && SAMPLE_I) begin
			next_gain_ctl = clamped[30:19];
			next_gain_valid = 1'h1;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			gain_ctl <= 12'h000;
			gain_valid <= 1'h0;
		end else begin
			gain_ctl <= next_gain_ctl;
			gain_valid <= next_gain_valid;
		end
	end

	// Outputs come straight from flip-flops, so the multiplier/shifter
	// never sees a half-updated gain word
	assign GAIN_EXP_O = gain_ctl[11:8];
	assign GAIN_MAN_O = gain_ctl[7:0];
	assign GAIN_VALID_O = gain_valid;
endmodule // agclf_loop

// *** rtl/agclf_params.svh ***
// Offsets, field positions, codes and reset values for the AGC loop filter
`ifndef AGCLF_PARAMS_SVH
`define AGCLF_PARAMS_SVH
`define AGCLF_UP_EXP_MSB 27
`define AGCLF_UP_EXP_LSB 24
`define AGCLF_UP_MAN_MSB 23
`define AGCLF_UP_MAN_LSB 16
`define AGCLF_LO_EXP_MSB 11
`define AGCLF_LO_EXP_LSB 8
`define AGCLF_LO_MAN_MSB 7
`define AGCLF_LO_MAN_LSB 0
`define AGCLF_THR_MSB 28
`define AGCLF_THR_LSB 16
`define AGCLF_G0_MAN_MSB 3
`define AGCLF_G0_MAN_LSB 0
`define AGCLF_G0_EXP_MSB 7
`define AGCLF_G0_EXP_LSB 4
`define AGCLF_G1_MAN_MSB 11
`define AGCLF_G1_MAN_LSB 8
`define AGCLF_G1_EXP_MSB 15
`define AGCLF_G1_EXP_LSB 12
`define AGCLF_HOLD_BIT 15
`define AGCLF_MEDIAN_BIT 16
`define AGCLF_MED_POS 13'h0400
`define AGCLF_MED_NEG 13'h1C00
`define AGCLF_EXP_MAX 4'hF
`define AGCLF_WORD_RST 32'h00000000
`endif

// *** rtl/agclf_pkg.sv ***
// Types shared by the AGC loop filter modules
package agclf_pkg;
	typedef logic [3:0] agclf_nib_t;
	typedef logic [12:0] agclf_err_t;
	typedef logic [31:0] agclf_acc_t;
endpackage

// *** rtl/agclf_scaler.sv ***
// Error scaler: mantissa over 16 then right shift by 15 minus exponent
`timescale 1ns/10ps
module agclf_scaler
	import agclf_pkg::*;
(
	agclf_gain_if.dst g // Gain set and error in, scaled step out
);
	`include "agclf_params.svh"
	logic signed [17:0] prod;
	logic signed [31:0] wide;
	logic [3:0] sh;
	always_comb begin
		// Error is placed at accumulator bits 27..15, then weighted
		prod = $signed(g.err) * $signed({1'b0, g.man});
		wide = 32'(prod) <<< 11;
		sh = `AGCLF_EXP_MAX - g.expo;
		g.step = wide >>> sh;
	end
endmodule // agclf_scaler

// *** testbench/agclf_far.sv ***
// Far side: magnitude source firing sample strobes
`timescale 1ns/10ps
module agclf_far(input wire logic clk_i, rst_i, // Clock, reset
	output logic smp_o = 0, output logic [12:0] mag_o = 0); // Strobe, level
	always @(posedge clk_i)
		{smp_o, mag_o} <= {!rst_i && $urandom % 3 > 0, 13'($urandom % 2048)};
endmodule // agclf_far

// *** testbench/agclf_loop_monitor.sv ***
// Port checker for the AGC loop filter
`timescale 1ns/10ps
module agclf_mon(input wire logic CLK_SYS_I, RST_I, SAMPLE_I, GAIN_VALID_O,
	input wire logic SYNC_INPUT_TWO_I, BACKEND_SOFT_RESET_WORD_I,
	input wire logic [12:0] MAGNITUDE_I, input wire logic [3:0] GAIN_EXP_O,
	input wire logic [31:0] AGC_GAIN_LIMITS_I, LOOP_PARAM_I, MODE_WORD_I,
	input wire logic [7:0] GAIN_MAN_O);
	wire logic [11:0] g = {GAIN_EXP_O, GAIN_MAN_O};
	wire logic [11:0] hi = AGC_GAIN_LIMITS_I[27:16];
	wire logic [11:0] lo = AGC_GAIN_LIMITS_I[11:0];
	wire logic s = SYNC_INPUT_TWO_I, k = MODE_WORD_I[15];
	wire logic c = s | BACKEND_SOFT_RESET_WORD_I & ~k;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	property p_v; SAMPLE_I && !c |=> GAIN_VALID_O; endproperty
	a_v: assert property (p_v) else $error("no valid");
	property p_n; !SAMPLE_I || c |=> !GAIN_VALID_O; endproperty
	a_n: assert property (p_n) else $error("stray valid");
	property p_u; GAIN_VALID_O |-> g <= $past(hi); endproperty
	a_u: assert property (p_u) else $error("over upper");
	property p_l; GAIN_VALID_O |-> g >= $past(lo); endproperty
	a_l: assert property (p_l) else $error("under lower");
	property p_s; !GAIN_VALID_O && !$past(RST_I) |-> $stable(g); endproperty
	a_s: assert property (p_s) else $error("gain moved");
	property p_r; disable iff (0) RST_I |=> !g && !GAIN_VALID_O; endproperty
	a_r: assert property (p_r) else $error("reset");
	property p_c; c ##1 SAMPLE_I && !c && MAGNITUDE_I > LOOP_PARAM_I[28:16]
		|=> g == $past(lo); endproperty
	a_c: assert property (p_c) else $error("clear");
	property p_h; k && SAMPLE_I && !s |=> GAIN_VALID_O; endproperty
	a_h: assert property (p_h) else $error("hold");
	cover property (c ##1 SAMPLE_I);
	cover property (SAMPLE_I && MODE_WORD_I[16]);
	cover property (SAMPLE_I && k && BACKEND_SOFT_RESET_WORD_I);
endmodule // agclf_mon
bind agclf_loop agclf_mon i_mon(.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
	.SAMPLE_I(SAMPLE_I), .GAIN_VALID_O(GAIN_VALID_O),
	.SYNC_INPUT_TWO_I(SYNC_INPUT_TWO_I),
	.BACKEND_SOFT_RESET_WORD_I(BACKEND_SOFT_RESET_WORD_I),
	.MAGNITUDE_I(MAGNITUDE_I), .GAIN_EXP_O(GAIN_EXP_O),
	.AGC_GAIN_LIMITS_I(AGC_GAIN_LIMITS_I), .LOOP_PARAM_I(LOOP_PARAM_I),
	.MODE_WORD_I(MODE_WORD_I), .GAIN_MAN_O(GAIN_MAN_O));

// *** testbench/tb_agc_loop_filter_control.sv ***
// Random bench for the AGC loop filter against a reference accumulator
`timescale 1ns/10ps
module tb_agc_loop_filter_control;
	logic clk = 0, rst = 1, sel = 0, syn = 0, sft = 0, smp, vld, ev = 0;
	logic [3:0] ge;
	logic [7:0] gm;
	logic [12:0] mag;
	logic [31:0] lim = 0, par = 0, md = 0;
	int miscompares = 0, samples_checked = 0, cyc = 0;
	longint a = 0;
	always #2 clk = ~clk;
	agclf_far i_far(.clk_i(clk), .rst_i(rst), .smp_o(smp), .mag_o(mag));
	agclf_loop i_dut(.CLK_SYS_I(clk), .RST_I(rst), .SAMPLE_I(smp),
		.MAGNITUDE_I(mag), .AGC_GAIN_LIMITS_I(lim), .LOOP_PARAM_I(par),
		.MODE_WORD_I(md), .LOOP_GAIN_SET_SELECT_I(sel), .SYNC_INPUT_TWO_I(syn),
		.BACKEND_SOFT_RESET_WORD_I(sft), .GAIN_EXP_O(ge), .GAIN_MAN_O(gm),
		.GAIN_VALID_O(vld));
	task chk(logic [11:0] e, s);
		samples_checked++;
		miscompares += int'(s !== e);
		if (s !== e) $display("[FAIL] gain exp %h got %h", e, s);
	endtask
	task chk_vld(logic e, s);
		samples_checked++;
		miscompares += int'(s !== e);
		if (s !== e) $display("[FAIL] valid exp %b got %b", e, s);
	endtask
	task wrap_up();
		miscompares += int'(cyc >= 1000);
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic longint nxt(longint v);
		logic [7:0] g = sel ? par[15:8] : par[7:0];
		logic signed [12:0] e = par[28:16] - mag;
		longint hi = lim[27:16] << 19;
		longint lo = lim[11:0] << 19;
		if (md[16]) e = e[12] ? 13'h1C00 : 13'h0400;
		v += (longint'(e) * int'(g[3:0]) * 2048) >>> (15 - g[7:4]);
		return v > hi ? hi : v < lo ? lo : v;
	endfunction
	always @(posedge clk) begin
		if (vld === 1'b1) chk(a[30:19], {ge, gm});
		if (!rst) chk_vld(ev, vld);
		ev = !rst && smp && !(syn || sft && !md[15]);
		if (rst || syn || sft && !md[15]) a = 0;
		else if (smp) a = nxt(a);
		if (++cyc == 1000) wrap_up();
	end
	initial begin
		void'($urandom(32'hA2B1));
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int r = 0; r < 12; r++) begin
			// Upper exponent kept below 15 so the sum cannot wrap 32 bits
			lim <= $urandom & 32'h06FF07FF | 32'h08000000;
			par <= r ? $urandom & 32'h07FFFFFF : 32'h0400FFFF;
			md <= r << 15;
			repeat (60) begin
				@(posedge clk);
				{sel, syn, sft} <= {1'($urandom), $urandom % 29 == 0,
					$urandom % 13 == 0};
			end
		end
		// Burst: clear, acquire on the fast set 1, then track on set 0
		@(posedge clk);
		{md, par, lim} <= {32'h00010000, 32'h0400FF81, 32'h0A000200};
		{sel, syn, sft} <= 3'h6;
		@(posedge clk);
		syn <= 1'h0;
		repeat (30) @(posedge clk);
		sel <= 1'h0;
		repeat (30) @(posedge clk);
		wrap_up();
	end
endmodule // tb_agc_loop_filter_control
